// file: common/cssb_pkg.sv
// shared constants and types for the codec serial slot buffer
package cssb_pkg;
  // ==========================================================
  // sizes
  localparam int NWORDS = 4;
  localparam int DW     = 16;
  localparam int AW     = 4;
  // ==========================================================
  // register word addresses
  localparam logic [3:0] ADDR_CTRL_A  = 4'h0;
  localparam logic [3:0] ADDR_CTRL_B  = 4'h1;
  localparam logic [3:0] ADDR_STATUS  = 4'h2;
  localparam logic [3:0] ADDR_TX_MASK = 4'h3;
  localparam logic [3:0] ADDR_RX_MASK = 4'h4;
  localparam logic [3:0] ADDR_TX_BUF  = 4'h8;
  localparam logic [3:0] ADDR_RX_BUF  = 4'hC;
  // ==========================================================
  // field positions
  localparam int CA_EN      = 0;
  localparam int CA_SLAVE   = 1;
  localparam int CA_IDLE    = 2;
  localparam int CA_REPEAT  = 3;
  localparam int CB_WS      = 0;
  localparam int CB_FLEN    = 4;
  localparam int CB_BLEN    = 8;
  localparam int CB_EARLY_JUSTIFY_SELECT    = 10;
  localparam int ST_EMPTY   = 0;
  localparam int ST_UNF     = 1;
  localparam int ST_FULL    = 2;
  localparam int ST_OVF     = 3;
  localparam int ST_SLOT    = 8;
  // ==========================================================
  // reset values
  localparam logic [3:0]  CTRL_A_RST = 4'h0;
  localparam logic [10:0] CTRL_B_RST = 11'h000;
  localparam logic [15:0] MASK_RST   = 16'h0000;
  localparam logic [15:0] WORD_RST   = 16'h0000;
  localparam logic [3:0]  FULL_WORD  = 4'hF;
  // ==========================================================
  // types
  typedef struct packed {
    logic       en;
    logic       slave;
    logic       idle_tri;
    logic       repeat_uf;
    logic       early_justify_select;
    logic [1:0] blen;
    logic [3:0] flen;
    logic [3:0] ws;
  } cssb_cfg_t;

  typedef enum {ST_IDLE, ST_WAIT, ST_RUN} cssb_state_t;
endpackage

// file: design/cssb_top.sv
// codec serial slot and buffer controller
// Contract
// R1: data starts one bit later, or same with justify
// R2: sixteen transmit slot enables, word-size slots
// R3: enabled tx slot loads shadow word, pointer advances
// R4: disabled tx slot drives low or tri-state
// R5: enables beyond frame length have no effect
// R6: tx word left justified, low bits ignored
// R7: software zeroes unused low tx bits
// R8: enabled rx slot stores shift register, pointer advances
// R9: each rx word own location, left justified
// R10: master emits sync at reset, slave resets
// R11: no buffering after frame end until sync
// R12: one shared counter advances per enabled slot
// R13: counter equals length field: wrap and transfer
// R14: transfer swaps shadow and buffer registers
// R15: tx empty sets at transfer, clears on write
// R16: tx underflow sets if buffer not rewritten
// R17: rx full until all used buffers read
// R18: rx overflow on unread location, overwrite
// R19: only used locations affect flags; the tx empty flag still clears on a tx write to any location, used or not
// R20: status mirrors current slot counter
// R21: word size field is length minus one
// R22: frame counter advances on word wrap
// R23: underflow sends zeros or repeats last word
// R24: interrupt request at each shadow transfer
// R25: interrupt is one system clock pulse
//
// The strobed register port and the address map were left to the implementer.
`timescale 1ns/1ps
module cssb_top (
  input  wire logic                    clk_sys,
  input  wire logic                    nrst,
  input  wire logic [cssb_pkg::AW-1:0] reg_addr,
  input  wire logic [15:0]             reg_wdata,
  input  wire logic                    reg_wr,
  input  wire logic                    reg_rd,
  output logic      [15:0]             reg_rdata,
  input  wire logic                    serial_bit_clock,
  input  wire logic                    frame_sync_pin_i,
  output logic                         frame_sync_pin_o,
  output logic                         frame_sync_pin_oe,
  input  wire logic                    serial_data_in,
  output logic                         serial_data_out,
  output logic                         serial_data_out_oe,
  output logic                         buf_irq
);
  localparam int N = cssb_pkg::NWORDS;

  function automatic logic buf_hit(input logic [3:0] a, input logic [3:0] base);
    buf_hit = (a[3:2] == base[3:2]);
  endfunction

  function automatic logic slot_on(input logic [15:0] mask, input logic [3:0] s,
                                   input logic [3:0] flen);
    slot_on = mask[s] && (s <= flen);
  endfunction

  // ==========================================================
  // pin synchronisers
  logic [2:0] pin_w;
  logic [2:0] s1_q;
  logic [2:0] s2_q;
  logic [2:0] s3_q;
  logic [2:0] filt_q;

  assign pin_w = {serial_data_in, frame_sync_pin_i, serial_bit_clock};

  genvar g;
  for (g = 0; g < 3; g++) begin : g_sync
    always_ff @(posedge clk_sys) begin
      if (!nrst) begin
        s1_q[g]   <= 1'b0;
        s2_q[g]   <= 1'b0;
        s3_q[g]   <= 1'b0;
        filt_q[g] <= 1'b0;
      end else begin
        s1_q[g] <= pin_w[g];
        s2_q[g] <= s1_q[g];
        s3_q[g] <= s2_q[g];
        if (s2_q[g] == s3_q[g]) begin
          filt_q[g] <= s3_q[g];
        end
      end
    end
  end

  logic bck_rise;
  logic bck_fall;
  assign bck_rise = (s2_q[0] == s3_q[0]) && s3_q[0] && !filt_q[0];
  assign bck_fall = (s2_q[0] == s3_q[0]) && !s3_q[0] && filt_q[0];

  // ==========================================================
  // registers
  logic [3:0]          ctrl_a_q;
  logic [10:0]         ctrl_b_q;
  logic [15:0]         tx_mask_q;
  logic [15:0]         rx_mask_q;
  cssb_pkg::cssb_cfg_t cfg;

  assign cfg.en        = ctrl_a_q[cssb_pkg::CA_EN];
  assign cfg.slave     = ctrl_a_q[cssb_pkg::CA_SLAVE];
  assign cfg.idle_tri  = ctrl_a_q[cssb_pkg::CA_IDLE];
  assign cfg.repeat_uf = ctrl_a_q[cssb_pkg::CA_REPEAT];
  assign cfg.ws        = ctrl_b_q[cssb_pkg::CB_WS +: 4];
  assign cfg.flen      = ctrl_b_q[cssb_pkg::CB_FLEN +: 4];
  assign cfg.blen      = ctrl_b_q[cssb_pkg::CB_BLEN +: 2];
  assign cfg.early_justify_select      = ctrl_b_q[cssb_pkg::CB_EARLY_JUSTIFY_SELECT];

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      ctrl_a_q  <= cssb_pkg::CTRL_A_RST;
      ctrl_b_q  <= cssb_pkg::CTRL_B_RST;
      tx_mask_q <= cssb_pkg::MASK_RST;
      rx_mask_q <= cssb_pkg::MASK_RST;
    end else if (reg_wr) begin
      unique case (reg_addr)
        cssb_pkg::ADDR_CTRL_A:  ctrl_a_q <= reg_wdata[3:0];
        cssb_pkg::ADDR_CTRL_B:  ctrl_b_q <= reg_wdata[10:0];
        // R2: per-slot transmit enables
        cssb_pkg::ADDR_TX_MASK: tx_mask_q <= reg_wdata;
        cssb_pkg::ADDR_RX_MASK: rx_mask_q <= reg_wdata;
        default: ;
      endcase
    end
  end

  logic       tx_wr_w;
  logic       rx_rd_w;
  logic [1:0] loc_w;
  assign tx_wr_w = reg_wr && buf_hit(reg_addr, cssb_pkg::ADDR_TX_BUF);
  assign rx_rd_w = reg_rd && buf_hit(reg_addr, cssb_pkg::ADDR_RX_BUF);
  assign loc_w   = reg_addr[1:0];

  // ==========================================================
  // frame position counters
  cssb_pkg::cssb_state_t state_q;
  cssb_pkg::cssb_state_t state_d;
  logic [3:0] bit_q;
  logic [3:0] bit_d;
  logic [3:0] slot_q;
  logic [3:0] slot_d;
  logic       fs_q;
  logic       fs_d;
  logic       at_last;

  assign at_last = (bit_q == cfg.ws) && (slot_q == cfg.flen);

  always_comb begin
    state_d = state_q;
    bit_d   = bit_q;
    slot_d  = slot_q;
    fs_d    = 1'b0;
    unique case (state_q)
      cssb_pkg::ST_IDLE: begin
        // R10: master starts on its own, slave on sync
        if (!cfg.slave || filt_q[1]) begin
          fs_d    = !cfg.slave;
          // R1: justify bit picks same or next bit period
          state_d = cfg.early_justify_select ? cssb_pkg::ST_RUN : cssb_pkg::ST_WAIT;
          bit_d   = 4'h0;
          slot_d  = 4'h0;
        end
      end
      cssb_pkg::ST_WAIT: begin
        state_d = cssb_pkg::ST_RUN;
      end
      cssb_pkg::ST_RUN: begin
        if (at_last) begin
          bit_d  = 4'h0;
          slot_d = 4'h0;
          // R11: slave halts until the next sync pulse
          if (cfg.slave) begin
            if (!filt_q[1]) begin
              state_d = cssb_pkg::ST_IDLE;
            end else if (!cfg.early_justify_select) begin
              state_d = cssb_pkg::ST_WAIT;
            end
          end
        // R21: word ends after ws plus one bits
        end else if (bit_q == cfg.ws) begin
          bit_d  = 4'h0;
          // R22: frame counter steps on word wrap
          slot_d = slot_q + 4'h1;
        end else begin
          bit_d = bit_q + 4'h1;
        end
        // R10: master sync marks the counter reset
        if (!cfg.slave) begin
          fs_d = cfg.early_justify_select ? (bit_d == 4'h0 && slot_d == 4'h0)
                          : (bit_d == cfg.ws && slot_d == cfg.flen);
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst || !cfg.en) begin
      state_q <= cssb_pkg::ST_IDLE;
      bit_q   <= 4'h0;
      slot_q  <= 4'h0;
      fs_q    <= 1'b0;
    end else if (bck_rise) begin
      state_q <= state_d;
      bit_q   <= bit_d;
      slot_q  <= slot_d;
      fs_q    <= fs_d;
    end
  end

  assign frame_sync_pin_o  = fs_q;
  assign frame_sync_pin_oe = cfg.en && !cfg.slave;

  // ==========================================================
  // shared buffer pointer and shadow transfer
  logic [1:0]   ptr_q;
  logic         slot_end;
  logic         tx_on;
  logic         rx_on;
  logic         adv;
  logic         xfer;
  logic [15:0]  rx_word;
  logic [15:0]  rx_sr_q;
  logic [N-1:0] used;

  assign slot_end = bck_fall && state_q == cssb_pkg::ST_RUN && bit_q == cfg.ws;
  // R5: enables past the frame length are masked
  assign tx_on    = slot_on(tx_mask_q, slot_q, cfg.flen);
  assign rx_on    = slot_on(rx_mask_q, slot_q, cfg.flen);
  // R12: one counter for either direction
  assign adv      = slot_end && (tx_on || rx_on);
  assign xfer     = adv && (ptr_q == cfg.blen);
  // R9: left justify the received bits
  assign rx_word  = {rx_sr_q[14:0], filt_q[2]} << (cssb_pkg::FULL_WORD - cfg.ws);

  for (g = 0; g < N; g++) begin : g_used
    assign used[g] = (2'(g) <= cfg.blen);
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst || !cfg.en) begin
      ptr_q <= 2'h0;
    end else if (adv) begin
      // R13: wrap at the length field
      ptr_q <= xfer ? 2'h0 : ptr_q + 2'h1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      rx_sr_q <= cssb_pkg::WORD_RST;
    end else if (bck_fall && state_q == cssb_pkg::ST_RUN) begin
      rx_sr_q <= {rx_sr_q[14:0], filt_q[2]};
    end
  end

  // ==========================================================
  // receive shadow and buffers
  logic [15:0]    rx_shadow_q [N];
  logic [N*16-1:0] rx_ld_vec;
  logic [15:0]    rx_rdata;
  logic [15:0]    tx_rdata;
  logic [N*16-1:0] tx_words;

  for (g = 0; g < N; g++) begin : g_rxsh
    always_ff @(posedge clk_sys) begin
      if (!nrst) begin
        rx_shadow_q[g] <= cssb_pkg::WORD_RST;
      // R8: store word at pointer
      end else if (slot_end && rx_on && ptr_q == 2'(g)) begin
        rx_shadow_q[g] <= rx_word;
      end
    end
    assign rx_ld_vec[g*16 +: 16] = (slot_end && rx_on && ptr_q == 2'(g)) ? rx_word
                                                                         : rx_shadow_q[g];
  end

  // R14: shadow words move into the receive buffers
  cssb_word_mem #(.N(N), .W(16)) u_rx_mem (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .wr_en   (1'b0),
    .wr_addr (2'h0),
    .wr_data (16'h0000),
    .ld_mask ({N{xfer}} & used),
    .ld_data (rx_ld_vec),
    .rd_addr (loc_w),
    .rd_data (rx_rdata),
    .words   ()
  );

  cssb_word_mem #(.N(N), .W(16)) u_tx_mem (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .wr_en   (tx_wr_w),
    .wr_addr (loc_w),
    .wr_data (reg_wdata),
    .ld_mask ({N{1'b0}}),
    .ld_data ({(N*16){1'b0}}),
    .rd_addr (loc_w),
    .rd_data (tx_rdata),
    .words   (tx_words)
  );

  // ==========================================================
  // transmit shadow and shifter
  logic [15:0]  tx_shadow_q [N];
  logic [15:0]  tx_sr_q;
  logic         tx_act_q;
  logic [N-1:0] unf_q;
  logic [N-1:0] written_q;

  for (g = 0; g < N; g++) begin : g_txsh
    always_ff @(posedge clk_sys) begin
      if (!nrst) begin
        tx_shadow_q[g] <= cssb_pkg::WORD_RST;
      // R14: buffers copied into transmit shadow
      end else if (xfer) begin
        tx_shadow_q[g] <= tx_words[g*16 +: 16];
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst || !cfg.en) begin
      tx_sr_q  <= cssb_pkg::WORD_RST;
      tx_act_q <= 1'b0;
    end else if (bck_rise) begin
      if (state_d != cssb_pkg::ST_RUN) begin
        tx_act_q <= 1'b0;
        tx_sr_q  <= cssb_pkg::WORD_RST;
      end else if (bit_d == 4'h0) begin
        // R3: load shadow word at slot start
        tx_act_q <= slot_on(tx_mask_q, slot_d, cfg.flen);
        // R23: zeros on underflow unless repeating
        if (!slot_on(tx_mask_q, slot_d, cfg.flen) || (unf_q[ptr_q] && !cfg.repeat_uf)) begin
          tx_sr_q <= cssb_pkg::WORD_RST;
        end else begin
          tx_sr_q <= tx_shadow_q[ptr_q];
        end
      end else begin
        // R6: only the top ws plus one bits leave
        tx_sr_q <= {tx_sr_q[14:0], 1'b0};
      end
    end
  end

  assign serial_data_out    = tx_sr_q[15];
  // R4: idle slots low or released
  assign serial_data_out_oe = cfg.en && (tx_act_q || !cfg.idle_tri);

  // ==========================================================
  // status flags
  logic         tx_empty_q;
  logic [N-1:0] unread_q;
  logic [N-1:0] ovf_q;

  for (g = 0; g < N; g++) begin : g_flag
    always_ff @(posedge clk_sys) begin
      if (!nrst) begin
        written_q[g] <= 1'b0;
        unf_q[g]     <= 1'b0;
        unread_q[g]  <= 1'b0;
        ovf_q[g]     <= 1'b0;
      end else begin
        if (tx_wr_w && loc_w == 2'(g)) begin
          written_q[g] <= 1'b1;
        end else if (xfer) begin
          written_q[g] <= 1'b0;
        end
        // R16: flag words not rewritten before transfer
        if (xfer && used[g] && !written_q[g]) begin
          unf_q[g] <= 1'b1;
        end else if (tx_wr_w && loc_w == 2'(g)) begin
          unf_q[g] <= 1'b0;
        end
        // R17: new data pending until read
        if (xfer && used[g]) begin
          unread_q[g] <= 1'b1;
        end else if (rx_rd_w && loc_w == 2'(g)) begin
          unread_q[g] <= 1'b0;
        end
        // R18: overwrite of unread location
        if (xfer && used[g] && unread_q[g]) begin
          ovf_q[g] <= 1'b1;
        end else if (rx_rd_w && loc_w == 2'(g)) begin
          ovf_q[g] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      tx_empty_q <= 1'b0;
    // R15: set at transfer wins over write clear
    end else if (xfer) begin
      tx_empty_q <= 1'b1;
    end else if (tx_wr_w) begin
      tx_empty_q <= 1'b0;
    end
  end

  logic [15:0] status_w;
  always_comb begin
    status_w = 16'h0000;
    status_w[cssb_pkg::ST_EMPTY] = tx_empty_q;
    // R19: only locations in use count
    status_w[cssb_pkg::ST_UNF]   = |(unf_q & used);
    status_w[cssb_pkg::ST_FULL]  = |(unread_q & used);
    status_w[cssb_pkg::ST_OVF]   = |(ovf_q & used);
    // R20: live slot counter
    status_w[cssb_pkg::ST_SLOT +: 4] = slot_q;
  end

  // ==========================================================
  // interrupt pulse
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      buf_irq <= 1'b0;
    end else begin
      // R24: one request per transfer
      // R25: single cycle after the transfer
      buf_irq <= xfer;
    end
  end

  // ==========================================================
  // register read port
  logic [15:0] rd_q;
  logic [1:0]  rd_src_q;

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      rd_q     <= 16'h0000;
      rd_src_q <= 2'h0;
    end else if (reg_rd) begin
      rd_src_q <= buf_hit(reg_addr, cssb_pkg::ADDR_TX_BUF) ? 2'h1 :
                  buf_hit(reg_addr, cssb_pkg::ADDR_RX_BUF) ? 2'h2 : 2'h0;
      unique case (reg_addr)
        cssb_pkg::ADDR_CTRL_A:  rd_q <= {12'h000, ctrl_a_q};
        cssb_pkg::ADDR_CTRL_B:  rd_q <= {5'h00, ctrl_b_q};
        cssb_pkg::ADDR_STATUS:  rd_q <= status_w;
        cssb_pkg::ADDR_TX_MASK: rd_q <= tx_mask_q;
        cssb_pkg::ADDR_RX_MASK: rd_q <= rx_mask_q;
        default:                rd_q <= 16'h0000;
      endcase
    end else begin
      rd_q     <= 16'h0000;
      rd_src_q <= 2'h0;
    end
  end

  assign reg_rdata = (rd_src_q == 2'h1) ? tx_rdata :
                     (rd_src_q == 2'h2) ? rx_rdata : rd_q;

  // ==========================================================
  // checks
  empty_set_a: assert property (@(posedge clk_sys) disable iff (!nrst) // R15
    xfer |=> tx_empty_q) else $error("tx empty not set at transfer");
  empty_clr_a: assert property (@(posedge clk_sys) disable iff (!nrst) // R15
    tx_wr_w && !xfer |=> !tx_empty_q) else $error("tx empty not cleared by write");
  irq_pulse_a: assert property (@(posedge clk_sys) disable iff (!nrst) // R25
    xfer ##1 !xfer |-> buf_irq ##1 !buf_irq) else $error("irq not a single pulse");
  ptr_wrap_a: assert property (@(posedge clk_sys) disable iff (!nrst) // R13
    xfer && cfg.en |=> ptr_q == 2'h0) else $error("pointer did not wrap");
  idle_low_a: assert property (@(posedge clk_sys) disable iff (!nrst) // R4
    cfg.en && !tx_act_q && !cfg.idle_tri |-> serial_data_out_oe && !serial_data_out)
    else $error("idle slot not driven low");
  idle_tri_a: assert property (@(posedge clk_sys) disable iff (!nrst) // R4
    !tx_act_q && cfg.idle_tri |-> !serial_data_out_oe) else $error("idle slot driven");
  slot_view_a: assert property (@(posedge clk_sys) disable iff (!nrst) // R20
    reg_rd && reg_addr == cssb_pkg::ADDR_STATUS |=>
    reg_rdata[cssb_pkg::ST_SLOT +: 4] == $past(slot_q)) else $error("slot field wrong");
  unf_set_a: assert property (@(posedge clk_sys) disable iff (!nrst) // R16
    xfer && !written_q[0] |=> status_w[cssb_pkg::ST_UNF]) else $error("underflow missed");
  rx_full_a: assert property (@(posedge clk_sys) disable iff (!nrst) // R17
    xfer |=> status_w[cssb_pkg::ST_FULL]) else $error("rx full not set");
  rx_ovf_a: assert property (@(posedge clk_sys) disable iff (!nrst) // R18
    xfer && unread_q[0] |=> status_w[cssb_pkg::ST_OVF]) else $error("overflow missed");
  fs_master_a: assert property (@(posedge clk_sys) disable iff (!nrst) // R10
    cfg.slave |-> !frame_sync_pin_oe && !frame_sync_pin_o) else $error("slave drives sync");
endmodule

// file: design/cssb_word_mem.sv
// four-word buffer bank with registered read port
`timescale 1ns/1ps
module cssb_word_mem #(
  parameter int N = 4,
  parameter int W = 16
) (
  input  wire logic                 clk_sys,
  input  wire logic                 nrst,
  input  wire logic                 wr_en,
  input  wire logic [1:0]           wr_addr,
  input  wire logic [W-1:0]         wr_data,
  input  wire logic [N-1:0]         ld_mask,
  input  wire logic [N*W-1:0]       ld_data,
  input  wire logic [1:0]           rd_addr,
  output logic      [W-1:0]         rd_data,
  output logic      [N*W-1:0]       words
);
  logic [W-1:0] mem_q [N];

  genvar g;
  for (g = 0; g < N; g++) begin : g_word
    always_ff @(posedge clk_sys) begin
      if (!nrst) begin
        mem_q[g] <= '0;
      end else if (ld_mask[g]) begin
        mem_q[g] <= ld_data[g*W +: W];
      end else if (wr_en && wr_addr == 2'(g)) begin
        mem_q[g] <= wr_data;
      end
    end
    assign words[g*W +: W] = mem_q[g];
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      rd_data <= '0;
    end else begin
      rd_data <= mem_q[rd_addr];
    end
  end
endmodule

// file: testbench/cssb_codec_model.sv
// behavioural codec model on the far side of the serial bus
`timescale 1ns/1ps
module cssb_codec_model #(
  parameter logic [63:0] WORDS = 64'hA5C3_1234_8001_FFFE
) (
  input  wire logic        run,
  input  wire logic        fs_in,
  input  wire logic        sdo,
  output logic             bclk,
  output logic             fs_out,
  output logic             sdi,
  output logic [63:0]      got
);
  int idx;

  initial begin
    bclk = 1'b0;
    sdi  = 1'b0;
    got  = '0;
    idx  = 99;
  end

  // master mode only: sync comes from the device
  assign fs_out = 1'b0;

  // ==========================================================
  // bit clock, parked low outside the run
  always #160 if (run || bclk) bclk = ~bclk;

  // ==========================================================
  // slot bits; device outputs lag the edge, so look at the rise
  // bit 0 follows the period with sync high
  always @(posedge bclk) begin
    if (idx < 64) got[63-idx] = sdo;
    idx = fs_in ? 0 : idx + 1;
    sdi = (idx < 64) ? WORDS[63-idx] : ~sdi;
  end
endmodule

// file: testbench/tb_cssb_top.sv
// self-checking bench for the codec serial slot buffer
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin fails++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module tb_cssb_top;
  localparam logic [63:0] CW = 64'hA5C3_1234_8001_FFFE;
  logic        clk_sys;
  logic        nrst;
  logic        reg_wr;
  logic        reg_rd;
  logic        run;
  logic [3:0]  reg_addr;
  logic [15:0] reg_wdata;
  logic [15:0] reg_rdata;
  logic [15:0] rdv;
  logic        bclk;
  logic        fs_o;
  logic        fs_oe;
  logic        fs_i;
  logic        sdi;
  logic        sdo;
  logic        sdo_oe;
  logic        buf_irq;
  logic [63:0] got;
  wire         sdo_w;
  int          fails;
  int          tests_run;

  // released data line reads back inverted
  assign sdo_w = sdo_oe ? sdo : ~sdo;

  cssb_top u_dut (
    .clk_sys            (clk_sys),
    .nrst               (nrst),
    .reg_addr           (reg_addr),
    .reg_wdata          (reg_wdata),
    .reg_wr             (reg_wr),
    .reg_rd             (reg_rd),
    .reg_rdata          (reg_rdata),
    .serial_bit_clock   (bclk),
    .frame_sync_pin_i   (fs_i),
    .frame_sync_pin_o   (fs_o),
    .frame_sync_pin_oe  (fs_oe),
    .serial_data_in     (sdi),
    .serial_data_out    (sdo),
    .serial_data_out_oe (sdo_oe),
    .buf_irq            (buf_irq)
  );

  cssb_codec_model #(.WORDS(CW)) u_codec (
    .run    (run),
    .fs_in  (fs_o),
    .sdo    (sdo_w),
    .bclk   (bclk),
    .fs_out (fs_i),
    .sdi    (sdi),
    .got    (got)
  );

  // ==========================================================
  // register bus tasks
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd   <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  task automatic wait_irq;
    int n;
    n = 0;
    while (buf_irq !== 1'b1 && n < 40000) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    if (n >= 40000) fails++;
    @(posedge clk_sys);
    #1;
  endtask

  task automatic complete_run;
    $display("checks=%0d mismatches=%0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // ==========================================================
  // clock and watchdog
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  initial begin
    #2_000_000;
    fails++;
    complete_run;
  end

  // ==========================================================
  // main sequence
  initial begin
    nrst = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 4'h0;
    reg_wdata = 16'h0000; run = 1'b0; fails = 0; tests_run = 0;
    repeat (2) @(posedge clk_sys);
    nrst <= 1'b1;
    // cleared registers, address 5 unmapped
    for (int a = 0; a < 6; a++) begin
      rd(4'(a), rdv);
      `CHK(rdv, 16'h0000)
    end
    wr(cssb_pkg::ADDR_TX_MASK, 16'h0005);
    wr(cssb_pkg::ADDR_RX_MASK, 16'h000F);
    rd(cssb_pkg::ADDR_TX_MASK, rdv);
    `CHK(rdv, 16'h0005)
    rd(cssb_pkg::ADDR_RX_MASK, rdv);
    `CHK(rdv, 16'h000F)
    // full-width words, so no spare low bits
    wr(cssb_pkg::ADDR_TX_BUF, 16'h9A51);
    wr(4'(cssb_pkg::ADDR_TX_BUF + 1), 16'h0BAD);
    wr(4'(cssb_pkg::ADDR_TX_BUF + 2), 16'hC3E7);
    wr(4'(cssb_pkg::ADDR_TX_BUF + 3), 16'h5AA5);
    wr(cssb_pkg::ADDR_CTRL_B, 16'h033F);
    wr(cssb_pkg::ADDR_CTRL_A, 16'h0001);
    run = 1'b1;
    wait_irq;
    `CHK({fs_oe, sdo_oe}, 2'b11)
    rd(cssb_pkg::ADDR_STATUS, rdv);
    `CHK(rdv & 16'h000F, 16'h0005)
    for (int i = 0; i < 4; i++) begin
      rd(4'(cssb_pkg::ADDR_RX_BUF + i), rdv);
      `CHK(rdv, 16'(CW >> (48 - 16 * i)))
    end
    rd(cssb_pkg::ADDR_STATUS, rdv);
    `CHK(rdv & 16'h000F, 16'h0001)
    wait_irq;
    // shared pointer, disabled slots low
    `CHK(got, {16'h9A51, 16'h0000, 16'hC3E7, 16'h0000})
    rd(cssb_pkg::ADDR_STATUS, rdv);
    `CHK(rdv & 16'h000F, 16'h0007)
    wr(cssb_pkg::ADDR_TX_BUF, 16'h7E01);
    rd(cssb_pkg::ADDR_STATUS, rdv);
    `CHK(rdv & 16'h0001, 16'h0000)
    wait_irq;
    rd(cssb_pkg::ADDR_STATUS, rdv);
    `CHK(rdv & 16'h000F, 16'h000F)
    wait_irq;
    // location 2 underflowed: silence in its slot
    `CHK(got, {16'h7E01, 16'h0000, 16'h0000, 16'h0000})
    rd(cssb_pkg::ADDR_RX_BUF, rdv);
    `CHK(rdv, CW[63:48])
    // released idle slots, underflowed words repeated
    wr(cssb_pkg::ADDR_CTRL_A, 16'h000D);
    wait_irq;
    wait_irq;
    `CHK(got[47:32], 16'hFFFF)
    `CHK(got[15:0], 16'hFFFF)
    `CHK({got[63:48], got[31:16]}, {16'h7E01, 16'hC3E7})
    run = 1'b0;
    complete_run;
  end
endmodule
